// ==== dv/bpbp_cls_model.sv ====
// Classification pipeline model: issues one frame request per bench command
`timescale 1ns/1ps
`default_nettype none
module bpbp_cls_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Command from the bench
  input  wire logic        reqGo,
  input  wire logic [77:0] reqBus,
  // Frame request toward the policer
  output var  logic        frmValid,
  output var  logic [77:0] frmBus
);
  // ---------------------------------------------------------------
  // Request register; fields churn while idle so stale data is unusable
  // ---------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      frmValid <= 1'b0;
      frmBus   <= 78'h0;
    end else if (reqGo) begin
      // Indices and service fields as classified
      frmValid <= 1'b1;
      frmBus   <= reqBus;
    end else begin
      // Idle: inverted pattern each cycle
      frmValid <= 1'b0;
      frmBus   <= ~frmBus;
    end
  end
endmodule
`default_nettype wire

// ==== dv/bpbp_policer_asserts.sv ====
// Port-level checker for the policer top, bound into every instance
`timescale 1ns/1ps
`default_nettype none
module bpbp_policer_asserts (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Frame request
  input wire logic        frmValid,
  input wire logic [2:0]  frmType,
  input wire logic [1:0]  frmDp,
  input wire logic [11:0] frmServiceIndex,
  input wire logic [11:0] frmSvcPolIdx,
  // Policing result
  input wire logic        resValid,
  input wire logic        resDiscard,
  input wire logic [1:0]  resDp,
  input wire logic        resBundleUsed,
  input wire logic        resYellow,
  input wire logic        resPrioValid,
  input wire logic [7:0]  resPrioIdx,
  input wire logic [5:0]  statEvent
);
  // ---------------------------------------------------------------
  // One clock domain, so clocking and reset are given once
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_res_follows: assert property (frmValid |=> resValid)
    else $error("Result missing after frame request");
  chk_res_cause: assert property (resValid |-> $past(frmValid))
    else $error("Result without a frame request");
  chk_prio_svc: assert property ((frmValid && (frmServiceIndex != 0 || frmSvcPolIdx != 0))
    |=> !resPrioValid)
    else $error("Priority policer used for service frame");
  chk_prio_bundle: assert property (resBundleUsed |-> !resPrioValid)
    else $error("Priority policer used beside bundle policer");
  chk_prio_idle: assert property (!resPrioValid |-> resPrioIdx == 8'h00)
    else $error("Priority index not zero while unused");
  chk_disc_event: assert property ((statEvent[2:0] != 0) |-> resDiscard && $onehot(statEvent))
    else $error("Discard event without a discard");
  chk_event_type: assert property ((statEvent != 0) |-> $past(frmType) ==
    {statEvent[5] | statEvent[2], statEvent[4] | statEvent[1], statEvent[3] | statEvent[0]})
    else $error("Statistics event of wrong traffic type");
  chk_yellow_bundle: assert property (resYellow |-> resBundleUsed)
    else $error("Yellow marking without bundle policer");
  chk_dp_raise: assert property ((resValid && !resDiscard) |-> resDp >= $past(frmDp))
    else $error("Drop precedence lowered");
endmodule
// Attach to every policer instance
bind bum_policer bpbp_policer_asserts u_chk (.clk_sys, .rstn, .frmValid, .frmType, .frmDp,
  .frmServiceIndex, .frmSvcPolIdx, .resValid, .resDiscard, .resDp, .resBundleUsed,
  .resYellow, .resPrioValid, .resPrioIdx, .statEvent);
`default_nettype wire

// ==== dv/bum_priority_bundle_policer_tb.sv ====
// Self-checking bench for the BUM, priority and bundle policer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module bum_priority_bundle_policer_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk_sys, rstn, regWr, regRd, reqGo, frmValid;
  logic        resValid, resDiscard, resBundleUsed, resYellow, resPrioValid;
  logic [7:0]  regAddr, resPrioIdx;
  logic [31:0] regWdata, regRdata;
  logic [77:0] reqBus, frmBus;
  logic [1:0]  resDp;
  logic [5:0]  statEvent;
  int          miscompares, checked;
  // Far side and device
  bpbp_cls_model u_cls (.clk_sys, .rstn, .reqGo, .reqBus, .frmValid, .frmBus);
  bum_policer dut (
    .clk_sys, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .frmValid,
    .frmType(frmBus[77:75]), .frmLen(frmBus[74:61]), .frmEncapLen(frmBus[60:53]),
    .frmDp(frmBus[52:51]), .frmVlanBumIdx(frmBus[50:49]), .frmSvcBumIdx(frmBus[48:47]),
    .frmSvcBumOvr(frmBus[46]), .frmServiceIndex(frmBus[45:34]), .frmSvcPolIdx(frmBus[33:22]),
    .frmPort(frmBus[21:20]), .frmQos(frmBus[19:17]), .frmRuleAction(frmBus[16:0]),
    .resValid, .resDiscard, .resDp, .resBundleUsed, .resYellow, .resPrioValid, .resPrioIdx,
    .statEvent
  );
  // ---------------------------------------------------------------
  // Bus and frame tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask
  // vs = {vlan index, service index, override}, pq = {port, qos}; encap fixed 50
  task automatic fr(input logic [2:0] t, input logic [13:0] l, input logic [1:0] dp,
                    input logic [4:0] vs, input logic [11:0] svc, input logic [11:0] pol,
                    input logic [4:0] pq, input logic [16:0] a);
    @(posedge clk_sys);
    reqGo  <= 1'b1;
    reqBus <= {t, l, 8'h32, dp, vs, svc, pol, pq, a};
    @(posedge clk_sys);
    reqGo <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rs(input logic d, input logic [5:0] s);
    `CHK({resValid, resDiscard, statEvent}, {1'b1, d, s})
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(8'h00, 32'h0000_0064);
    rd(8'h04, 32'h0000_0089);
    rd(8'h80, 32'h0000_1800);
    rd(8'h18, 32'h0000_0000);
  endtask
  task automatic t_fields;
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_1FFF);
    wr(8'h44, 32'hFFFF_FFFF);
    rd(8'h44, 32'h000F_FFFF);
    wr(8'hB0, 32'hFFFF_FFFF);
    rd(8'hB0, 32'h0000_3FFF);
    wr(8'hB4, 32'hFFFF_FFFF);
    rd(8'hB4, 32'h000F_FFFF);
  endtask
  // Frame-mode entry 1 with zero thresholds: second frame is excess
  task automatic t_bum;
    wr(8'h08, 32'h0000_003F);
    wr(8'h50, 32'h0000_1000);
    fr(3'h1, 14'd64, 2'h0, 5'h08, 12'h0, 12'h0, 5'h0, 17'h0);
    rs(1'b0, 6'h08);
    fr(3'h1, 14'd64, 2'h0, 5'h08, 12'h0, 12'h0, 5'h0, 17'h0);
    rs(1'b1, 6'h01);
    wr(8'h04, 32'h0000_00A1);
    fr(3'h4, 14'd64, 2'h0, 5'h08, 12'h0, 12'h0, 5'h0, 17'h0);
    rs(1'b1, 6'h04);
    fr(3'h2, 14'd64, 2'h0, 5'h08, 12'h0, 12'h0, 5'h0, 17'h0);
    rs(1'b0, 6'h10);
    wr(8'h08, 32'h0000_0038);
    fr(3'h4, 14'd64, 2'h0, 5'h08, 12'h0, 12'h0, 5'h0, 17'h0);
    rs(1'b1, 6'h00);
    // Excess with increment 1 raises DP instead of dropping
    wr(8'h70, 32'h0000_1004);
    fr(3'h1, 14'd64, 2'h1, 5'h18, 12'h0, 12'h0, 5'h0, 17'h0);
    `CHK({resDiscard, resDp}, {1'b0, 2'h1})
    fr(3'h1, 14'd64, 2'h1, 5'h18, 12'h0, 12'h0, 5'h0, 17'h0);
    `CHK({resDiscard, resDp}, {1'b0, 2'h2})
    rd(8'h10, 32'h0000_0006);
  endtask
  // Override to entry 2: gap -16, encap excluded, 2044 bytes per frame
  task automatic t_svc;
    wr(8'h60, 32'h0000_0F00);
    for (int i = 0; i < 3; i++) begin
      fr(3'h1, 14'd2060, 2'h0, 5'h0D, 12'h001, 12'h0, 5'h0, 17'h0);
      rs(i == 2, (i < 2) ? 6'h08 : 6'h00);
    end
  endtask
  // Port 1 base 0xFE plus qos 5 wraps to 0x03
  task automatic t_prio;
    wr(8'h00, 32'h0001_0064);
    wr(8'h14, 32'h0000_FE00);
    fr(3'h0, 14'd64, 2'h0, 5'h0, 12'h0, 12'h0, 5'h0D, 17'h0);
    `CHK({resPrioValid, resPrioIdx}, {1'b1, 8'h03})
    fr(3'h0, 14'd64, 2'h0, 5'h0, 12'h001, 12'h0, 5'h0D, 17'h0);
    `CHK({resPrioValid, resPrioIdx}, {1'b0, 8'h00})
    fr(3'h0, 14'd64, 2'h0, 5'h0, 12'h0, 12'h005, 5'h0D, 17'h0);
    `CHK({resPrioValid, resPrioIdx}, {1'b0, 8'h00})
    fr(3'h0, 14'd64, 2'h0, 5'h0, 12'h0, 12'h0, 5'h0D, 17'h10000);
    `CHK(resBundleUsed, 1'b0)
  endtask
  // Uncoupled bundle 0, ceiling 1, increment 1, zero thresholds
  task automatic t_bundle;
    wr(8'h00, 32'h0007_0064);
    wr(8'h80, 32'h0000_0804);
    fr(3'h0, 14'd100, 2'h0, 5'h0, 12'h0, 12'h0, 5'h0D, 17'h10000);
    `CHK({resBundleUsed, resYellow, resDp, resPrioValid}, 5'h10)
    fr(3'h0, 14'd100, 2'h2, 5'h0, 12'h0, 12'h0, 5'h0D, 17'h10000);
    `CHK({resBundleUsed, resYellow, resDp, resPrioValid}, 5'h1E)
    fr(3'h0, 14'd4000, 2'h2, 5'h0, 12'h0, 12'h0, 5'h0D, 17'h10000);
    `CHK({resDiscard, resYellow}, 2'h1)
    fr(3'h0, 14'd100, 2'h2, 5'h0, 12'h0, 12'h0, 5'h0D, 17'h10000);
    `CHK({resBundleUsed, resDiscard}, 2'h3)
  endtask
  // Coupled bundle 1, color-blind: green fills both buckets, then both close
  task automatic t_couple;
    wr(8'h90, 32'h0000_3800);
    fr(3'h0, 14'd100, 2'h2, 5'h0, 12'h0, 12'h0, 5'h0, 17'h10001);
    `CHK({resDiscard, resYellow, resDp}, 4'h2)
    fr(3'h0, 14'd4000, 2'h2, 5'h0, 12'h0, 12'h0, 5'h0, 17'h10001);
    `CHK({resDiscard, resYellow}, 2'h0)
    fr(3'h0, 14'd100, 2'h2, 5'h0, 12'h0, 12'h0, 5'h0, 17'h10001);
    `CHK({resDiscard, resYellow}, 2'h2)
    // Tick every clock and full rates drain both buckets again
    wr(8'h00, 32'h0006_0000);
    wr(8'h94, 32'h000F_FF00);
    wr(8'h98, 32'h000F_FF00);
    fr(3'h0, 14'd100, 2'h2, 5'h0, 12'h0, 12'h0, 5'h0, 17'h10001);
    `CHK({resDiscard, resYellow}, 2'h0)
  endtask
  // ---------------------------------------------------------------
  // Verdict, clock, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic finish_test;
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Run needs about 140 cycles; allow many more
  initial begin
    #50000;
    miscompares++;
    finish_test;
  end
  initial begin
    {rstn, regWr, regRd, reqGo} = 4'h0;
    regAddr  = 8'h00;
    regWdata = 32'h0;
    reqBus   = 78'h0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_fields;
    t_bum;
    t_svc;
    t_prio;
    t_bundle;
    t_couple;
    finish_test;
  end
endmodule
`default_nettype wire

// ==== hw/bum_bucket.v ====
// One leaky bucket: fills on accepted frames, drains on ticks
`timescale 1ns/1ps
`default_nettype none
module bum_bucket (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Drain control
  input  wire        leakTick,
  input  wire [11:0] rate,
  // Fill control
  input  wire        addEn,
  input  wire [15:0] addAmt,
  // Current fill level
  output reg  [19:0] fill
);
  wire [19:0] drained;  // Fill after drain, floored at zero
  wire [20:0] summed;   // Fill after add, one spare bit
  assign drained = !leakTick ? fill :
                   (fill > {8'h00, rate}) ? fill - {8'h00, rate} : 20'h00000;
  assign summed  = {1'b0, drained} + (addEn ? {5'h00, addAmt} : 21'h000000);
  // Saturate rather than wrap, a wrap would reopen a full bucket
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fill <= 20'h00000;
    end else begin
      fill <= summed[20] ? 20'hFFFFF : summed[19:0];
    end
  end
endmodule
`default_nettype wire

// ==== hw/bum_policer.v ====
// Top of the BUM, priority and bundle dual-bucket policer
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bum_regs.vh"
module bum_policer (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  // Frame request from classification
  input  wire        frmValid,
  input  wire [13:0] frmLen,
  input  wire [7:0]  frmEncapLen,
  input  wire [2:0]  frmType,
  input  wire [1:0]  frmDp,
  input  wire [1:0]  frmVlanBumIdx,
  input  wire [1:0]  frmSvcBumIdx,
  input  wire        frmSvcBumOvr,
  input  wire [11:0] frmServiceIndex,
  input  wire [11:0] frmSvcPolIdx,
  input  wire [1:0]  frmPort,
  input  wire [2:0]  frmQos,
  input  wire [16:0] frmRuleAction,
  // Policing result, one cycle after request
  output reg         resValid,
  output reg         resDiscard,
  output reg  [1:0]  resDp,
  output reg         resBundleUsed,
  output reg         resYellow,
  output reg         resPrioValid,
  output reg  [7:0]  resPrioIdx,
  output reg  [5:0]  statEvent
);
  // ---------------------------------------------------------------------------
  // Configuration storage
  // ---------------------------------------------------------------------------
  reg  [15:0] unitTicks_r;       // Leak unit ticks
  reg         prioEn_r;          // Priority policing enable
  reg         leakEn_r;          // Leak enable for the bundle buckets
  reg         addEnG_r;          // Bundle bucket add enable
  reg  [8:0]  tmask_r;           // Traffic type mask, 3 per bucket
  reg  [5:0]  evMask_r;          // Statistics event mask
  reg  [15:0] evCount_r;         // Counted statistics events
  reg  [31:0] prioBase_r;        // Per-port priority base, 8 bits each
  reg  [12:0] bumCfg_r [0:3];    // BUM entry config words
  reg  [19:0] bumLb_r  [0:11];   // BUM buckets: rate, threshold
  reg  [13:0] bdCfg_r  [0:3];    // Bundle entry config words
  reg  [19:0] bundle_dual_bucket_r   [0:7];    // Bundle buckets: rate, threshold
  wire [19:0] bumFill  [0:11];   // BUM bucket levels
  wire [19:0] bdFill   [0:7];    // Bundle bucket levels
  wire [3:0]  tick;              // Scaled leak ticks

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  wire [1:0] tblSel;   // Table window
  wire [1:0] ent;      // Entry in window
  wire [1:0] wrd;      // Word in entry
  assign tblSel = regAddr[7:6];
  assign ent    = regAddr[5:4];
  assign wrd    = regAddr[3:2];

  // Software writes; table words past the entry are ignored
  always @(posedge clk_sys or negedge rstn) begin : pWr
    integer i;
    if (!rstn) begin
      unitTicks_r <= `BUM_RST_TICKS;
      prioEn_r    <= 1'b0;
      leakEn_r    <= 1'b0;
      addEnG_r    <= 1'b0;
      tmask_r     <= `BUM_RST_TMASK;
      evMask_r    <= 6'h00;
      prioBase_r  <= 32'h00000000;
      for (i = 0; i < 4; i = i + 1) begin
        bumCfg_r[i] <= 13'h0000;
        bdCfg_r[i]  <= {1'b0, `BUM_RST_GREEN, 11'h000}; // Color-blind
      end
      for (i = 0; i < 12; i = i + 1) begin
        bumLb_r[i] <= 20'h00000;
      end
      for (i = 0; i < 8; i = i + 1) begin
        bundle_dual_bucket_r[i] <= 20'h00000;
      end
    end else if (regWr) begin
      if (tblSel == `BUM_TBL_BUM) begin
        if (wrd == 2'h0) begin
          bumCfg_r[ent] <= regWdata[12:0];
        end else begin
          bumLb_r[ent*3 + wrd - 1] <= regWdata[19:0];
        end
      end else if (tblSel == `BUM_TBL_BUNDLE_DUAL_BUCKET) begin
        if (wrd == 2'h0) begin
          bdCfg_r[ent] <= regWdata[13:0];
        end else if (wrd != 2'h3) begin
          bundle_dual_bucket_r[{ent, 1'b0} + wrd - 1] <= regWdata[19:0];
        end
      end else begin
        case (regAddr)
          `BUM_OFF_CTRL: begin
            unitTicks_r <= regWdata[`BUM_CTRL_TICKS_MSB:0];
            prioEn_r    <= regWdata[`BUM_CTRL_PRIO_EN];
            leakEn_r    <= regWdata[`BUM_CTRL_LEAK_EN];
            addEnG_r    <= regWdata[`BUM_CTRL_ADD_EN];
          end
          `BUM_OFF_TMASK:    tmask_r    <= regWdata[8:0];
          `BUM_OFF_EVMASK:   evMask_r   <= regWdata[5:0];
          `BUM_OFF_PRIOBASE: prioBase_r <= regWdata;
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped addresses read zero
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h00000000;
    if (tblSel == `BUM_TBL_BUM) begin
      rdMux = (wrd == 2'h0) ? {19'h0, bumCfg_r[ent]} : {12'h0, bumLb_r[ent*3 + wrd - 1]};
    end else if (tblSel == `BUM_TBL_BUNDLE_DUAL_BUCKET) begin
      if (wrd == 2'h0) begin
        rdMux = {18'h0, bdCfg_r[ent]};
      end else if (wrd != 2'h3) begin
        rdMux = {12'h0, bundle_dual_bucket_r[{ent, 1'b0} + wrd - 1]};
      end
    end else begin
      case (regAddr)
        `BUM_OFF_CTRL:     rdMux = {13'h0, addEnG_r, leakEn_r, prioEn_r, unitTicks_r};
        `BUM_OFF_TMASK:    rdMux = {23'h0, tmask_r};
        `BUM_OFF_EVMASK:   rdMux = {26'h0, evMask_r};
        `BUM_OFF_STATUS:   rdMux = {16'h0, resPrioIdx, resPrioValid, resYellow,
                                    resBundleUsed, resDp, resDiscard, 2'h0};
        `BUM_OFF_EVCOUNT:  rdMux = {16'h0, evCount_r};
        `BUM_OFF_PRIOBASE: rdMux = prioBase_r;
        default:           rdMux = 32'h00000000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 32'h00000000;
    end else begin
      regRdata <= regRd ? rdMux : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------------------
  // BUM policer selection and sizing
  // ---------------------------------------------------------------------------
  wire        svcFrame;   // Frame belongs to a service
  wire [1:0]  bumIdx;     // Chosen BUM policer
  wire [12:0] bcfg;       // Its config word
  wire [6:0]  gapB;       // Its signed size adjust
  wire [16:0] bumSize;    // Signed adjusted size
  wire [15:0] bumAmt;     // Bucket increment
  assign svcFrame = (frmServiceIndex != 12'h000);
  assign bumIdx   = (svcFrame && frmSvcBumOvr) ? frmSvcBumIdx : frmVlanBumIdx;
  assign bcfg     = bumCfg_r[bumIdx];
  assign gapB     = bcfg[`BUM_CFG_GAP_LSB +: 7];
  // Stripped encapsulation bytes count unless excluded
  assign bumSize  = {3'h0, frmLen} + {{10{gapB[6]}}, gapB} +
                    (bcfg[`BUM_CFG_EXCL_BIT] ? 17'h00000 : {9'h000, frmEncapLen});
  // Frame mode adds one unit; a negative size floors at zero
  assign bumAmt   = bcfg[`BUM_CFG_FRAME_BIT] ? 16'h0001 :
                    (bumSize[16] ? 16'h0000 : bumSize[15:0]);

  // Per bucket position: applicable traffic and over-threshold state
  wire [2:0] bumApp;   // Bucket applies to this frame type
  wire [2:0] bumExc;   // Bucket over its burst threshold
  genvar j;
  generate
    for (j = 0; j < 3; j = j + 1) begin : gPos
      wire [19:0] lb;
      wire [19:0] lvl;
      assign lb  = bumLb_r[bumIdx*3 + j];
      assign lvl = bumFill[bumIdx*3 + j];
      assign bumApp[j] = |(tmask_r[j*3 +: 3] & frmType);
      assign bumExc[j] = bcfg[`BUM_CFG_FRAME_BIT] ? (lvl > {12'h0, lb[7:0]}) :
                         (lvl[19:`BUM_THR_SHIFT] > {1'b0, lb[7:0]});
    end
  endgenerate

  wire bumApplies;   // Some bucket polices this frame
  wire bumOver;      // Some applicable bucket is exceeded
  wire bumDrop;      // Frame is discarded
  assign bumApplies = frmValid && (|bumApp);
  assign bumOver    = |(bumApp & bumExc);
  // A zero increment means excess traffic cannot be remarked and is dropped
  assign bumDrop    = bumApplies && bumOver &&
                      (bcfg[`BUM_CFG_DPINC_LSB +: 2] == 2'h0);

  // ---------------------------------------------------------------------------
  // Bundle dual-bucket selection and coloring
  // ---------------------------------------------------------------------------
  wire        bdOn;      // Bundle policer in effect
  wire [1:0]  bdIdx;     // Chosen bundle policer
  wire [13:0] dcfg;      // Its config word
  wire [6:0]  gapD;      // Its signed size adjust
  wire [16:0] bdSize;    // Signed adjusted size
  wire [15:0] bdAmt;     // Bucket increment
  wire        green;     // Frame enters green
  wire        cOk;       // Committed bucket has room
  wire        eOk;       // Excess bucket has room
  wire        bdGreen;   // Leaves green
  wire        bdYellow;  // Leaves yellow
  wire        bdDrop;    // Discarded by bundle
  assign bdOn   = frmValid && frmRuleAction[16] && leakEn_r && addEnG_r;
  assign bdIdx  = frmRuleAction[1:0];
  assign dcfg   = bdCfg_r[bdIdx];
  assign gapD   = dcfg[`BUM_CFG_GAP_LSB +: 7];
  assign bdSize = {3'h0, frmLen} + {{10{gapD[6]}}, gapD};
  assign bdAmt  = bdSize[16] ? 16'h0000 : bdSize[15:0];
  assign green  = (frmDp <= dcfg[`BUM_CFG_GREEN_LSB +: 2]);
  assign cOk    = (bdFill[{bdIdx, 1'b0}][19:`BUM_THR_SHIFT] <= {1'b0, bundle_dual_bucket_r[{bdIdx, 1'b0}][7:0]});
  assign eOk    = (bdFill[{bdIdx, 1'b1}][19:`BUM_THR_SHIFT] <= {1'b0, bundle_dual_bucket_r[{bdIdx, 1'b1}][7:0]});
  assign bdGreen  = bdOn && green && cOk;
  assign bdYellow = bdOn && !bdGreen && eOk;
  assign bdDrop   = bdOn && !bdGreen && !eOk;

  // ---------------------------------------------------------------------------
  // Buckets and leak ticks
  // ---------------------------------------------------------------------------
  bum_tick uTick (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .unitTicks (unitTicks_r),
    .tick      (tick)
  );

  genvar k;
  generate
    for (k = 0; k < 12; k = k + 1) begin : gBum
      // Entry k/3, position k%3; drains at the entry's own scale
      bum_bucket uB (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .leakTick (tick[bumCfg_r[k/3][`BUM_CFG_SCALE_LSB +: 2]]),
        .rate     (bumLb_r[k][`BUM_LB_RATE_LSB +: 12]),
        .addEn    (bumApplies && !bumDrop && (bumIdx == k/3) && bumApp[k%3]),
        .addAmt   (bumAmt),
        .fill     (bumFill[k])
      );
    end
    for (k = 0; k < 8; k = k + 1) begin : gBd
      // Uncoupled: each color fills its own bucket; coupled: bucket 1 sees green and yellow
      bum_bucket uB (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .leakTick (leakEn_r && tick[bdCfg_r[k/2][`BUM_CFG_SCALE_LSB +: 2]]),
        .rate     (bundle_dual_bucket_r[k][`BUM_LB_RATE_LSB +: 12]),
        .addEn    (addEnG_r && (bdIdx == k/2) && ((k%2 == 0) ? bdGreen :
                   (bdYellow || (bdGreen && dcfg[`BUM_CFG_COUPLE_BIT])))),
        .addAmt   (bdAmt),
        .fill     (bdFill[k])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Priority policer selection
  // ---------------------------------------------------------------------------
  wire       prioSel;   // Priority policing applies
  wire [7:0] prioIdx;   // Port base plus QoS class
  assign prioSel = frmValid && prioEn_r && (frmServiceIndex == 12'h000) &&
                   (frmSvcPolIdx == 12'h000) && !frmRuleAction[16];
  assign prioIdx = prioBase_r[frmPort*8 +: 8] + {5'h00, frmQos};

  // Raise DP saturating at 3
  function [1:0] dpAdd;
    input [1:0] dp;
    input [1:0] inc;
    reg   [2:0] s;
    begin
      s     = {1'b0, dp} + {1'b0, inc};
      dpAdd = s[2] ? 2'h3 : s[1:0];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Result and statistics registers
  // ---------------------------------------------------------------------------
  reg [1:0] dpNxt;   // DP after both policers
  always @* begin
    dpNxt = frmDp;
    if (bumApplies && bumOver && !bumDrop) begin
      dpNxt = dpAdd(dpNxt, bcfg[`BUM_CFG_DPINC_LSB +: 2]);
    end
    if (bdYellow) begin
      dpNxt = dpAdd(dpNxt, dcfg[`BUM_CFG_DPINC_LSB +: 2]);
    end
  end

  // Events per frame type: BUM discards in low half, BUM passes in high half
  wire [5:0] evNxt;
  assign evNxt = {evMask_r[5:3] & frmType & {3{bumApplies && !bumDrop}},
                  evMask_r[2:0] & frmType & {3{bumDrop}}};

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resValid      <= 1'b0;
      resDiscard    <= 1'b0;
      resDp         <= 2'h0;
      resBundleUsed <= 1'b0;
      resYellow     <= 1'b0;
      resPrioValid  <= 1'b0;
      resPrioIdx    <= 8'h00;
      statEvent     <= 6'h00;
    end else begin
      resValid      <= frmValid;
      resDiscard    <= bumDrop || bdDrop;
      resDp         <= dpNxt;
      resBundleUsed <= bdOn;
      resYellow     <= bdYellow;
      resPrioValid  <= prioSel;
      resPrioIdx    <= prioSel ? prioIdx : 8'h00;
      statEvent     <= evNxt;
    end
  end

  // Event counter; a software clear in an event cycle leaves a count of one
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evCount_r <= 16'h0000;
    end else if (|statEvent) begin
      evCount_r <= (regWr && regAddr == `BUM_OFF_EVCOUNT) ? 16'h0001 : evCount_r + 16'h0001;
    end else if (regWr && regAddr == `BUM_OFF_EVCOUNT) begin
      evCount_r <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ==== hw/bum_regs.vh ====
// Register map, field positions, reset values and figures of the BUM/priority/bundle policer
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef BUM_REGS_VH
`define BUM_REGS_VH
// Global register offsets (byte addresses)
`define BUM_OFF_CTRL      8'h00
`define BUM_OFF_TMASK     8'h04
`define BUM_OFF_EVMASK    8'h08
`define BUM_OFF_STATUS    8'h0C
`define BUM_OFF_EVCOUNT   8'h10
`define BUM_OFF_PRIOBASE  8'h14
// Table windows: addr[7:6] picks table, [5:4] entry, [3:2] word
`define BUM_TBL_BUM       2'h1
`define BUM_TBL_BUNDLE_DUAL_BUCKET      2'h2
// CTRL fields
`define BUM_CTRL_TICKS_MSB  15
`define BUM_CTRL_PRIO_EN    16
`define BUM_CTRL_LEAK_EN    17
`define BUM_CTRL_ADD_EN     18
// Entry config word fields (scale, DP increment, gap in both; exclude, frame BUM only; green, couple bundle only)
`define BUM_CFG_SCALE_LSB   0
`define BUM_CFG_DPINC_LSB   2
`define BUM_CFG_GAP_LSB     4
`define BUM_CFG_EXCL_BIT    11
`define BUM_CFG_FRAME_BIT   12
`define BUM_CFG_GREEN_LSB   11
`define BUM_CFG_COUPLE_BIT  13
// Bucket word fields
`define BUM_LB_RATE_LSB     8
// Reset values
`define BUM_RST_TICKS       16'h0064
`define BUM_RST_TMASK       9'h089
`define BUM_RST_GREEN       2'h3
// Byte mode thresholds count in 2 KB units
`define BUM_THR_SHIFT       11
`endif

// ==== hw/bum_tick.v ====
// Leak tick generator: base tick and three x8 scaled ticks
`timescale 1ns/1ps
`default_nettype none
module bum_tick (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Base period in clocks, minus one
  input  wire [15:0] unitTicks,
  // One pulse per scale step
  output wire [3:0]  tick
);
  reg  [15:0] baseCnt_r;   // Base period counter
  reg  [2:0]  stg_r [1:3]; // Divide-by-8 stages
  // Base tick when count reaches the period; zero ticks every clock
  assign tick[0] = (baseCnt_r >= unitTicks);
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      baseCnt_r <= 16'h0000;
    end else if (tick[0]) begin
      baseCnt_r <= 16'h0000;
    end else begin
      baseCnt_r <= baseCnt_r + 16'h0001;
    end
  end
  // Each stage multiplies granularity by eight
  genvar g;
  generate
    for (g = 1; g < 4; g = g + 1) begin : gStage
      assign tick[g] = tick[g-1] && (stg_r[g] == 3'h7);
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stg_r[g] <= 3'h0;
        end else if (tick[g-1]) begin
          stg_r[g] <= stg_r[g] + 3'h1;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
